/* File: include/tlc_pkg.sv */
// constants and carriers for the trusted launch configuration bank
`default_nettype none
package tlc_pkg;

  localparam int unsigned TLC_ADDR_W = 12;
  localparam int unsigned TLC_SLOTS  = 10;

  typedef enum logic [1:0] {
    TLC_SPACE_PUBLIC  = 2'h0,
    TLC_SPACE_PRIVATE = 2'h1,
    TLC_SPACE_TRUSTED = 2'h2
  } tlc_space_t;

  typedef struct packed {
    logic                  valid;
    logic                  write;
    tlc_space_t            space;
    logic [TLC_ADDR_W-1:0] addr;
    logic [7:0]            be;
    logic [63:0]           wdata;
  } tlc_req_t;

  typedef struct packed {
    logic        ack;
    logic [63:0] rdata;
  } tlc_rsp_t;

  // register offsets
  localparam logic [TLC_ADDR_W-1:0] TLC_OFS_CLOSE_PRIVATE = 12'h048;
  localparam logic [TLC_ADDR_W-1:0] TLC_OFS_IDENT         = 12'h110;
  localparam logic [TLC_ADDR_W-1:0] TLC_OFS_LOCK_BASE     = 12'h230;
  localparam logic [TLC_ADDR_W-1:0] TLC_OFS_UNLOCK_BASE   = 12'h238;
  localparam logic [TLC_ADDR_W-1:0] TLC_OFS_LAUNCH_BASE   = 12'h270;
  localparam logic [TLC_ADDR_W-1:0] TLC_OFS_LAUNCH_SIZE   = 12'h278;
  localparam logic [TLC_ADDR_W-1:0] TLC_OFS_JOIN_BASE     = 12'h290;
  localparam logic [TLC_ADDR_W-1:0] TLC_OFS_HEAP_BASE     = 12'h300;
  localparam logic [TLC_ADDR_W-1:0] TLC_OFS_HEAP_SIZE     = 12'h308;
  localparam logic [TLC_ADDR_W-1:0] TLC_OFS_MONSEG_BASE   = 12'h310;
  localparam logic [TLC_ADDR_W-1:0] TLC_OFS_MONSEG_SIZE   = 12'h318;
  localparam logic [TLC_ADDR_W-1:0] TLC_OFS_SCRATCH_LOCK  = 12'h320;
  localparam logic [TLC_ADDR_W-1:0] TLC_OFS_SCRATCH_FREE  = 12'h328;
  localparam logic [TLC_ADDR_W-1:0] TLC_OFS_OPEN_LOC1     = 12'h380;
  localparam logic [TLC_ADDR_W-1:0] TLC_OFS_CLOSE_LOC1    = 12'h388;
  localparam logic [TLC_ADDR_W-1:0] TLC_OFS_OPEN_LOC2     = 12'h390;
  localparam logic [TLC_ADDR_W-1:0] TLC_OFS_CLOSE_LOC2    = 12'h398;
  localparam logic [TLC_ADDR_W-1:0] TLC_OFS_KEY_HASH      = 12'h400;
  localparam logic [TLC_ADDR_W-1:0] TLC_OFS_KEY_HASH_END  = 12'h420;

  // identifier field layout
  localparam int unsigned TLC_ID_VENDOR_LSB = 0;
  localparam int unsigned TLC_ID_DEVICE_LSB = 16;
  localparam int unsigned TLC_ID_REV_LSB    = 32;
  localparam int unsigned TLC_ID_EXT_LSB    = 48;

  // lock classes of the storage slots
  localparam logic [1:0] TLC_LOCK_NONE   = 2'h0;
  localparam logic [1:0] TLC_LOCK_PUBLIC = 2'h1;
  localparam logic [1:0] TLC_LOCK_ALL    = 2'h2;

  // slot order: id ext, launch base, launch size, join, heap base, heap size,
  // monitor base, monitor size, lockable scratch, free scratch
  localparam logic [TLC_ADDR_W-1:0] TLC_SLOT_OFS [TLC_SLOTS] = '{
    TLC_OFS_IDENT, TLC_OFS_LAUNCH_BASE, TLC_OFS_LAUNCH_SIZE, TLC_OFS_JOIN_BASE,
    TLC_OFS_HEAP_BASE, TLC_OFS_HEAP_SIZE, TLC_OFS_MONSEG_BASE, TLC_OFS_MONSEG_SIZE,
    TLC_OFS_SCRATCH_LOCK, TLC_OFS_SCRATCH_FREE};

  localparam logic [63:0] TLC_SLOT_MASK [TLC_SLOTS] = '{
    64'hFFFF_0000_0000_0000, 64'h0000_00FF_FFFF_F000, 64'hFFFF_FFFF_FFFF_FFFF,
    64'h0000_00FF_FFFF_FFFF, 64'hFFFF_FFFF_FFFF_FFFF, 64'hFFFF_FFFF_FFFF_FFFF,
    64'hFFFF_FFFF_FFFF_FFFF, 64'hFFFF_FFFF_FFFF_FFFF, 64'hFFFF_FFFF_FFFF_FFFF,
    64'hFFFF_FFFF_FFFF_FFFF};

  localparam logic [1:0] TLC_SLOT_LOCK [TLC_SLOTS] = '{
    TLC_LOCK_PUBLIC, TLC_LOCK_NONE, TLC_LOCK_NONE, TLC_LOCK_NONE,
    TLC_LOCK_PUBLIC, TLC_LOCK_PUBLIC, TLC_LOCK_ALL, TLC_LOCK_ALL,
    TLC_LOCK_PUBLIC, TLC_LOCK_NONE};

  localparam logic [63:0] TLC_SLOT_RESET = 64'h0000_0000_0000_0000;

  localparam logic       TLC_FLAG_RESET = 1'b0;
  localparam int unsigned TLC_SLOT_IDENT = 0;

endpackage
`default_nettype wire

/* File: hdl/tlc_key_rom.sv */
// read-only key hash store, five 64-bit words with registered read data
`timescale 1ns/1ps
`default_nettype none
module tlc_key_rom
  import tlc_pkg::*;
#(
  parameter logic [256:0] KEY_HASH = {1'b1, {16{16'hA5C3}}}
)
(
  input  wire logic        clk,
  input  wire logic [2:0]  word_sel,
  output var  logic [63:0] word_data
);

  logic [63:0] words [5];

  genvar w;
  generate
    for (w = 0; w < 4; w++)
    begin : g_word
      assign words[w] = KEY_HASH[w*64 +: 64];
    end
  endgenerate
  // top word carries only the single bit 256
  assign words[4] = {63'h0, KEY_HASH[256]};

  always_ff @(posedge clk)
  begin
    word_data <= (word_sel < 3'h5) ? words[word_sel] : 64'h0000_0000_0000_0000;
  end

endmodule
`default_nettype wire

/* File: hdl/tlc_config_space.sv */
// trusted launch configuration register bank with lock and locality control
//
// How it works
// [RQ1] identifier reads fixed vendor, device and revision codes in low 48 bits.
// [RQ2] identifier extension writable; public writes ignored once base is locked.
// [RQ3] lock-base command write locks the lockable pointers and scratch.
// [RQ4] unlock-base command write releases lock; public writes allowed again.
// [RQ5] commands are write-only byte registers; data ignored, the write triggers.
// [RQ6] lock, unlock and locality commands act only from trusted space or open private space.
// [RQ7] launch-code base holds bits 39:12 only; other bits read zero.
// [RQ8] launch-memory size is a plain 64-bit mailbox, never interpreted.
// [RQ9] join-code base holds bits 39:0; upper bits read zero.
// [RQ10] heap base, heap size, first scratch: locked blocks public writes only.
// [RQ11] monitor segment base and size: locked blocks every write.
// [RQ12] second scratch pad is free read/write, lock has no effect.
// [RQ13] open and close locality 1 commands switch its trusted decode.
// [RQ14] locality 2 decodes trusted only while it and private space are open.
// [RQ15] opening private opens locality 2; closing private closes it.
// [RQ16] closed locality 2 range is never flagged as trusted.
// [RQ17] issuer sends locality 2 commands trusted or private while private is open.
// [RQ18] key hash at its offset is read-only; writes have no effect.
// [RQ19] pointer registers keep address bits above the 4G boundary.
// [RQ20] base-locked flag set by lock command, cleared by unlock or reset.
// [RQ21] close-private command stops ordinary private-space cycles reaching the bank.
// [RQ22] public writes to read-only or private-only registers change nothing.
// [RQ23] reset clears lock and all open states.
`timescale 1ns/1ps
`default_nettype none
module tlc_config_space
  import tlc_pkg::*;
#(
  parameter logic [15:0] VENDOR_CODE   = 16'h1234,  // arbitrary value
  parameter logic [15:0] DEVICE_CODE   = 16'h5678,  // arbitrary value
  parameter logic [15:0] REVISION_CODE = 16'h0001   // arbitrary value
)
(
  input  wire logic     clk,
  input  wire logic     reset,
  input  wire tlc_req_t req,
  output var  tlc_rsp_t rsp,
  input  wire logic     open_private,
  output var  logic     private_open,
  output var  logic     base_locked_flag,
  output var  logic     locality_one_open,
  output var  logic     locality_two_open,
  output var  logic     locality_two_trusted
);

  // storage and status
  logic [63:0] store [TLC_SLOTS];
  logic [63:0] rdata_reg;
  logic        ack_reg;
  logic        key_sel_reg;
  logic [63:0] key_word;

  // access qualification
  wire is_public  = (req.space == TLC_SPACE_PUBLIC);
  wire is_trusted = (req.space == TLC_SPACE_TRUSTED);
  // private cycles count only while private space is open
  wire privileged = is_trusted || ((req.space == TLC_SPACE_PRIVATE) && private_open); // see [RQ21]
  wire reachable  = is_public || privileged;
  wire wr_cycle   = req.valid && req.write && (req.be != 8'h00);
  wire rd_cycle   = req.valid && !req.write && reachable;
  wire cmd_wr     = wr_cycle && privileged; // see [RQ6] see [RQ5] see [RQ17]

  wire hit_lock        = (req.addr == TLC_OFS_LOCK_BASE);
  wire hit_unlock      = (req.addr == TLC_OFS_UNLOCK_BASE);
  wire hit_close_priv  = (req.addr == TLC_OFS_CLOSE_PRIVATE);
  wire hit_open_loc1   = (req.addr == TLC_OFS_OPEN_LOC1);
  wire hit_close_loc1  = (req.addr == TLC_OFS_CLOSE_LOC1);
  wire hit_open_loc2   = (req.addr == TLC_OFS_OPEN_LOC2);
  wire hit_close_loc2  = (req.addr == TLC_OFS_CLOSE_LOC2);
  wire hit_key         = (req.addr >= TLC_OFS_KEY_HASH) && (req.addr <= TLC_OFS_KEY_HASH_END);

  wire lock_cmd        = cmd_wr && hit_lock;        // see [RQ3]
  wire unlock_cmd      = cmd_wr && hit_unlock;      // see [RQ4]
  wire close_priv_cmd  = cmd_wr && hit_close_priv;  // see [RQ21]
  wire open_loc1_cmd   = cmd_wr && hit_open_loc1;   // see [RQ13]
  wire close_loc1_cmd  = cmd_wr && hit_close_loc1;  // see [RQ13]
  wire open_loc2_cmd   = cmd_wr && hit_open_loc2;
  wire close_loc2_cmd  = cmd_wr && hit_close_loc2;

  // byte enables widened to a bit mask
  logic [63:0] be_mask;
  genvar b;
  generate
    for (b = 0; b < 8; b++)
    begin : g_be
      assign be_mask[b*8 +: 8] = {8{req.be[b]}};
    end
  endgenerate

  // per-slot write qualification and storage
  logic [TLC_SLOTS-1:0] slot_hit;
  logic [TLC_SLOTS-1:0] slot_wr;
  logic [63:0]          next_store [TLC_SLOTS];

  genvar s;
  generate
    for (s = 0; s < TLC_SLOTS; s++)
    begin : g_slot
      wire lock_ok = (TLC_SLOT_LOCK[s] == TLC_LOCK_NONE) ||              // see [RQ12]
                     ((TLC_SLOT_LOCK[s] == TLC_LOCK_PUBLIC) &&
                      !(base_locked_flag && is_public)) ||              // see [RQ10] see [RQ2]
                     ((TLC_SLOT_LOCK[s] == TLC_LOCK_ALL) && !base_locked_flag); // see [RQ11]
      assign slot_hit[s] = (req.addr == TLC_SLOT_OFS[s]);
      assign slot_wr[s]  = wr_cycle && reachable && slot_hit[s] && lock_ok; // see [RQ22]
      // unimplemented bits are masked so they always read zero
      assign next_store[s] = ((store[s] & ~be_mask) | (req.wdata & be_mask))
                             & TLC_SLOT_MASK[s]; // see [RQ7] see [RQ9] see [RQ19] see [RQ8]

      always_ff @(posedge clk)
      begin
        if (reset)
          store[s] <= TLC_SLOT_RESET;
        else if (slot_wr[s])
          store[s] <= next_store[s];
      end
    end
  endgenerate

  // identifier composed of fixed codes and the stored extension
  wire [63:0] ident_word = {store[TLC_SLOT_IDENT][63:TLC_ID_EXT_LSB], REVISION_CODE,
                            DEVICE_CODE, VENDOR_CODE}; // see [RQ1]

  // read selection, commands and unmapped offsets read zero
  logic [63:0] next_rdata;
  always_comb
  begin
    next_rdata = 64'h0000_0000_0000_0000;
    for (int i = 0; i < TLC_SLOTS; i++)
    begin
      if (slot_hit[i])
        next_rdata = (i == TLC_SLOT_IDENT) ? ident_word : store[i];
    end
    if (!rd_cycle)
      next_rdata = 64'h0000_0000_0000_0000;
  end

  // key hash comes from its own store; no write path exists into it
  wire [2:0] key_index = 3'(req.addr[5:3]);
  tlc_key_rom u_key_rom (
    .clk       (clk),
    .word_sel  (key_index),
    .word_data (key_word)
  );

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ack_reg     <= 1'b0;
      rdata_reg   <= 64'h0000_0000_0000_0000;
      key_sel_reg <= 1'b0;
    end
    else
    begin
      ack_reg     <= req.valid;
      rdata_reg   <= next_rdata;
      key_sel_reg <= rd_cycle && hit_key; // see [RQ18]
    end
  end

  assign rsp.ack   = ack_reg;
  assign rsp.rdata = key_sel_reg ? key_word : rdata_reg;

  // lock flag
  always_ff @(posedge clk)
  begin
    if (reset)
      base_locked_flag <= TLC_FLAG_RESET; // see [RQ23]
    else if (lock_cmd)
      base_locked_flag <= 1'b1; // see [RQ20] see [RQ3]
    else if (unlock_cmd)
      base_locked_flag <= 1'b0; // see [RQ4] see [RQ20]
  end

  // private space, opened by the launch logic, closed by command; open wins
  always_ff @(posedge clk)
  begin
    if (reset)
      private_open <= TLC_FLAG_RESET;
    else if (open_private)
      private_open <= 1'b1;
    else if (close_priv_cmd)
      private_open <= 1'b0; // see [RQ21]
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      locality_one_open <= TLC_FLAG_RESET; // see [RQ23]
    else if (open_loc1_cmd)
      locality_one_open <= 1'b1; // see [RQ13]
    else if (close_loc1_cmd)
      locality_one_open <= 1'b0;
  end

  // locality 2 follows private space as well as its own commands
  always_ff @(posedge clk)
  begin
    if (reset)
      locality_two_open <= TLC_FLAG_RESET; // see [RQ23]
    else if (open_private || open_loc2_cmd)
      locality_two_open <= 1'b1; // see [RQ15]
    else if (close_priv_cmd || close_loc2_cmd)
      locality_two_open <= 1'b0; // see [RQ15]
  end

  // closed range falls back to normal decode outside this block
  assign locality_two_trusted = locality_two_open && private_open; // see [RQ14] see [RQ16]

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_lock_sets_flag: assert property ( // see [RQ3]
    lock_cmd |=> base_locked_flag)
    else $error("lock command did not set the lock flag");

  a_unlock_clears: assert property ( // see [RQ4]
    unlock_cmd |=> !base_locked_flag)
    else $error("unlock command did not clear the lock flag");

  a_public_cmd_ignored: assert property ( // see [RQ6]
    (req.valid && req.write && is_public && hit_lock && !base_locked_flag)
      |=> !base_locked_flag)
    else $error("public lock command took effect");

  a_heap_public_locked: assert property ( // see [RQ10]
    (base_locked_flag && wr_cycle && is_public && req.addr == TLC_OFS_HEAP_BASE)
      |=> $stable(store[4]))
    else $error("public write changed locked heap base");

  a_monseg_all_locked: assert property ( // see [RQ11]
    (base_locked_flag && wr_cycle && req.addr == TLC_OFS_MONSEG_BASE)
      |=> $stable(store[6]))
    else $error("write changed locked monitor base");

  a_launch_low_zero: assert property ( // see [RQ7]
    store[1][11:0] == 12'h000 && store[1][63:40] == 24'h00_0000)
    else $error("launch base reserved bits not zero");

  a_ident_codes: assert property ( // see [RQ1]
    (rd_cycle && req.addr == TLC_OFS_IDENT)
      |=> rsp.ack && rsp.rdata[47:0] == {REVISION_CODE, DEVICE_CODE, VENDOR_CODE})
    else $error("identifier codes read wrong");

  a_loc2_needs_priv: assert property ( // see [RQ14] see [RQ16]
    ((close_loc2_cmd || !private_open) && !open_private) |=> !locality_two_trusted)
    else $error("locality 2 trusted while a gate is closed");

  a_close_priv_loc2: assert property ( // see [RQ15]
    (close_priv_cmd && !open_private) |=> !locality_two_open && !private_open)
    else $error("close private left locality 2 open");

  a_ack_one_cycle: assert property (
    req.valid |=> rsp.ack ##1 (rsp.ack == $past(req.valid)))
    else $error("answer not one cycle after request");

  c_lock_unlock: cover property (lock_cmd ##[1:200] unlock_cmd);
  c_key_read: cover property (rd_cycle && hit_key ##1 rsp.ack);
  c_loc2_trusted: cover property (open_private ##1 locality_two_trusted);

endmodule
`default_nettype wire

/* File: testbench/tlc_host_model.sv */
// processor-side model issuing public, private and trusted register cycles
`timescale 1ns/1ps
`default_nettype none
module tlc_host_model
  import tlc_pkg::*;
(
  input  wire logic     clk,
  output var  tlc_req_t req,
  input  wire tlc_rsp_t rsp
);
  initial req = '0;

  // one request cycle, answer taken in the next; released fields show
  // inverted junk so a design that samples late never sees stale values
  task automatic xfer(input logic w, input tlc_space_t sp, input logic [11:0] a,
                      input logic [7:0] b, input logic [63:0] d,
                      output logic [63:0] q, output logic ok);
    tlc_req_t idle;
    @(posedge clk);
    #1;
    req = '{valid: 1'b1, write: w, space: sp, addr: a, be: b, wdata: d};
    @(posedge clk);
    #1;
    ok = rsp.ack;
    q = rsp.rdata;
    // one assignment, so the bus never carries two values in one step
    idle = ~req;
    idle.valid = 1'b0;
    req = idle;
  endtask

  // commands leave as single-byte writes; caller picks public, private or trusted
  task automatic cmd(input tlc_space_t sp, input logic [11:0] a, input logic [7:0] d,
                     output logic ok);
    logic [63:0] q;
    xfer(1'b1, sp, a, 8'h01, {8{d}}, q, ok);
  endtask
endmodule
`default_nettype wire

/* File: testbench/tb_tlc_config_space.sv */
// self-checking bench for the trusted launch configuration bank
`timescale 1ns/1ps
`default_nettype none
module tb_tlc_config_space
  import tlc_pkg::*;
;
  localparam logic [47:0]  ID_LOW = {16'h0001, 16'h5678, 16'h1234};
  localparam logic [256:0] KEY    = {1'b1, {16{16'hA5C3}}};
  localparam logic [1:0]   CLS [TLC_SLOTS] = '{2'h1, 2'h0, 2'h0, 2'h0, 2'h1,
                                               2'h1, 2'h2, 2'h2, 2'h1, 2'h0};
  logic        clk;
  logic        reset;
  logic        open_private;
  tlc_req_t    req;
  tlc_rsp_t    rsp;
  logic        private_open;
  logic        base_locked_flag;
  logic        locality_one_open;
  logic        locality_two_open;
  logic        locality_two_trusted;
  int          err_total;
  int          checks_done;
  int          i;
  logic [63:0] q;
  logic        ok;
  tlc_space_t  sp_alt;
  logic [63:0] store [TLC_SLOTS];

  tlc_config_space dut_u (
    .clk                  (clk),
    .reset                (reset),
    .req                  (req),
    .rsp                  (rsp),
    .open_private         (open_private),
    .private_open         (private_open),
    .base_locked_flag     (base_locked_flag),
    .locality_one_open    (locality_one_open),
    .locality_two_open    (locality_two_open),
    .locality_two_trusted (locality_two_trusted)
  );

  tlc_host_model host_u (
    .clk (clk),
    .req (req),
    .rsp (rsp)
  );

  initial clk = 1'b0;
  always #25 clk = ~clk;

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // flags in order: private, locked, loc1, loc2, loc2 trusted
  task automatic flg(input logic [4:0] e);
    chk({59'h0, private_open, base_locked_flag, locality_one_open,
         locality_two_open, locality_two_trusted}, {59'h0, e});
  endtask

  task automatic wr(input tlc_space_t sp, input logic [11:0] a, input logic [63:0] d);
    host_u.xfer(1'b1, sp, a, 8'hFF, d, q, ok);
    chk({63'h0, ok}, 64'h1);
  endtask

  task automatic rd(input tlc_space_t sp, input logic [11:0] a, input logic [63:0] e);
    host_u.xfer(1'b0, sp, a, 8'h00, 64'h0, q, ok);
    chk({63'h0, ok}, 64'h1);
    chk(q, e);
  endtask

  task automatic cm(input tlc_space_t sp, input logic [11:0] a, input logic [4:0] f);
    host_u.cmd(sp, a, 8'h5A, ok);
    chk({63'h0, ok}, 64'h1);
    flg(f);
  endtask

  function automatic logic [63:0] view(input int k, input logic [63:0] v);
    return (v & TLC_SLOT_MASK[k]) | (k == 0 ? {16'h0, ID_LOW} : 64'h0);
  endfunction

  function automatic logic [63:0] pat(input int k, input int n);
    return {8{4'(k), 4'(n)}};
  endfunction

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // whole run is well under a thousand cycles
  initial
  begin
    #(5000 * 50);
    err_total++;
    $display("BAD %0t watchdog expired", $time);
    end_sim;
  end

  initial
  begin
    reset = 1'b1;
    open_private = 1'b0;
    err_total = 0;
    checks_done = 0;
    repeat (3) @(posedge clk);
    #1;
    reset = 1'b0;
    flg(5'h00);
    rd(TLC_SPACE_PUBLIC, TLC_OFS_IDENT, {16'h0, ID_LOW});
    for (i = 1; i < TLC_SLOTS; i++)
      rd(TLC_SPACE_TRUSTED, TLC_SLOT_OFS[i], 64'h0);
    for (i = 0; i < 5; i++)
    begin
      wr(TLC_SPACE_TRUSTED, TLC_OFS_KEY_HASH + 12'(8 * i), 64'h0);
      rd(TLC_SPACE_PUBLIC, TLC_OFS_KEY_HASH + 12'(8 * i), 64'(KEY >> (64 * i)));
    end
    $display("test reset and read-only done");
    // private space still closed: nothing may land
    wr(TLC_SPACE_PRIVATE, TLC_OFS_SCRATCH_FREE, 64'hDEAD_BEEF_0000_0001);
    rd(TLC_SPACE_PUBLIC, TLC_OFS_SCRATCH_FREE, 64'h0);
    cm(TLC_SPACE_PRIVATE, TLC_OFS_LOCK_BASE, 5'h00);
    cm(TLC_SPACE_PUBLIC, TLC_OFS_LOCK_BASE, 5'h00);
    @(posedge clk);
    #1;
    open_private = 1'b1;
    @(posedge clk);
    #1;
    open_private = 1'b0;
    flg(5'h13);
    cm(TLC_SPACE_PUBLIC, TLC_OFS_LOCK_BASE, 5'h13);
    $display("test private gating done");
    for (i = 0; i < TLC_SLOTS; i++)
    begin
      store[i] = 64'hFFFF_FFFF_FFFF_FFFF;
      wr(TLC_SPACE_PUBLIC, TLC_SLOT_OFS[i], store[i]);
      rd(TLC_SPACE_PRIVATE, TLC_SLOT_OFS[i], view(i, store[i]));
    end
    rd(TLC_SPACE_PUBLIC, TLC_OFS_LAUNCH_BASE, 64'h0000_00FF_FFFF_F000);
    rd(TLC_SPACE_PUBLIC, TLC_OFS_JOIN_BASE, 64'h0000_00FF_FFFF_FFFF);
    host_u.xfer(1'b1, TLC_SPACE_PUBLIC, TLC_OFS_SCRATCH_FREE, 8'h0F,
                64'h1111_2222_3333_4444, q, ok);
    chk({63'h0, ok}, 64'h1);
    store[9] = 64'hFFFF_FFFF_3333_4444;
    rd(TLC_SPACE_PUBLIC, TLC_OFS_SCRATCH_FREE, store[9]);
    $display("test field masks done");
    cm(TLC_SPACE_PRIVATE, TLC_OFS_LOCK_BASE, 5'h1B);
    for (i = 0; i < TLC_SLOTS; i++)
    begin
      wr(TLC_SPACE_PUBLIC, TLC_SLOT_OFS[i], pat(1, i));
      if (CLS[i] == 2'h0)
        store[i] = pat(1, i);
      rd(TLC_SPACE_PUBLIC, TLC_SLOT_OFS[i], view(i, store[i]));
      sp_alt = (i % 2) ? TLC_SPACE_TRUSTED : TLC_SPACE_PRIVATE;
      wr(sp_alt, TLC_SLOT_OFS[i], pat(2, i));
      if (CLS[i] != 2'h2)
        store[i] = pat(2, i);
      rd(TLC_SPACE_PRIVATE, TLC_SLOT_OFS[i], view(i, store[i]));
    end
    cm(TLC_SPACE_PRIVATE, TLC_OFS_UNLOCK_BASE, 5'h13);
    for (i = 0; i < TLC_SLOTS; i++)
    begin
      store[i] = pat(3, i);
      wr(TLC_SPACE_PUBLIC, TLC_SLOT_OFS[i], store[i]);
      rd(TLC_SPACE_PUBLIC, TLC_SLOT_OFS[i], view(i, store[i]));
    end
    $display("test lock and unlock done");
    cm(TLC_SPACE_PRIVATE, TLC_OFS_OPEN_LOC1, 5'h17);
    cm(TLC_SPACE_PRIVATE, TLC_OFS_CLOSE_LOC1, 5'h13);
    cm(TLC_SPACE_TRUSTED, TLC_OFS_CLOSE_LOC2, 5'h10);
    cm(TLC_SPACE_PRIVATE, TLC_OFS_OPEN_LOC2, 5'h13);
    cm(TLC_SPACE_PUBLIC, TLC_OFS_OPEN_LOC1, 5'h13);
    cm(TLC_SPACE_PRIVATE, TLC_OFS_CLOSE_PRIVATE, 5'h00);
    rd(TLC_SPACE_PRIVATE, TLC_OFS_SCRATCH_FREE, 64'h0);
    rd(TLC_SPACE_TRUSTED, TLC_OFS_SCRATCH_FREE, store[9]);
    cm(TLC_SPACE_TRUSTED, TLC_OFS_OPEN_LOC2, 5'h02);
    rd(TLC_SPACE_PUBLIC, 12'h7F8, 64'h0);
    $display("test localities done");
    cm(TLC_SPACE_TRUSTED, TLC_OFS_LOCK_BASE, 5'h0A);
    @(posedge clk);
    #1;
    reset = 1'b1;
    @(posedge clk);
    #1;
    reset = 1'b0;
    flg(5'h00);
    rd(TLC_SPACE_TRUSTED, TLC_OFS_HEAP_BASE, 64'h0);
    $display("test mid-run reset done");
    end_sim;
  end
endmodule
`default_nettype wire
